// [hw/port_query_cfg.svh]
// constants for the ascii output-status query responder
// assumes: included by bare name from design files
`ifndef PORT_QUERY_CFG_SVH
`define PORT_QUERY_CFG_SVH
`define CH_HEADER 8'h3A
`define CH_CR 8'h0D
`define CH_LF 8'h0A
`define FUNC_READ 8'h03
`define START_ADDR 16'h9004
`define REG_COUNT 16'h0001
`define BYTE_COUNT 8'h02
`define ADDR_MIN 8'h01
`define ADDR_MAX 8'h10
`define QUERY_BYTES 4'h6
`define RESP_CHARS 5'h0F
`define IDX_FUNC 4'h1
`define IDX_SAH 4'h2
`define IDX_SAL 4'h3
`define IDX_CNH 4'h4
`define IDX_CNL 4'h5
`endif

// [hw/port_query_pkg.sv]
// types for the ascii output-status query responder
// assumes: nothing beyond the cfg header
package port_query_pkg;
    typedef enum logic [2:0] {
        RX_IDLE, RX_HI, RX_LO, RX_CR, RX_LF, TX_RUN
    } pq_state_t;
endpackage

// [hw/hex_tx_framer.sv]
// response framer: builds the reply character by character
// assumes: tx_ready from the serial transmitter on the same clock
`timescale 1ns/1ps
`include "port_query_cfg.svh"
module hex_tx_framer import port_query_pkg::*; (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_sync_n,
    // request
    input wire logic start,
    input wire logic [7:0] slave_addr,
    input wire logic [15:0] port_word,
    output logic busy,
    // character stream
    output logic [7:0] tx_data,
    output logic tx_valid,
    input wire logic tx_ready
);
    typedef struct packed {
        logic busy;
        logic [4:0] idx;
        logic [7:0] addr;
        logic [15:0] word;
    } fr_t;
    fr_t s_r, s_nxt;

    function automatic logic [7:0] hex_ch(input logic [3:0] n);
        hex_ch = (n < 4'hA) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
    endfunction

    logic [7:0] longitudinal_check;
    logic [7:0] ch;
    // two's complement of the byte sum
    assign longitudinal_check = 8'h00 - (s_r.addr + `FUNC_READ + `BYTE_COUNT
        + s_r.word[15:8] + s_r.word[7:0]);

    always_comb begin
        case (s_r.idx)
            5'h00: ch = `CH_HEADER;
            5'h01: ch = hex_ch(s_r.addr[7:4]);
            5'h02: ch = hex_ch(s_r.addr[3:0]);
            5'h03: ch = hex_ch(4'(`FUNC_READ >> 4));
            5'h04: ch = hex_ch(4'(`FUNC_READ & 8'h0F));
            5'h05: ch = hex_ch(4'(`BYTE_COUNT >> 4));
            5'h06: ch = hex_ch(4'(`BYTE_COUNT & 8'h0F));
            5'h07: ch = hex_ch(s_r.word[15:12]);
            5'h08: ch = hex_ch(s_r.word[11:8]);
            5'h09: ch = hex_ch(s_r.word[7:4]);
            5'h0A: ch = hex_ch(s_r.word[3:0]);
            5'h0B: ch = hex_ch(longitudinal_check[7:4]);
            5'h0C: ch = hex_ch(longitudinal_check[3:0]);
            5'h0D: ch = `CH_CR;
            default: ch = `CH_LF;
        endcase
    end

    always_comb begin
        s_nxt = s_r;
        if (!s_r.busy) begin
            if (start) begin
                s_nxt.busy = 1'b1;
                s_nxt.idx = 5'h00;
                s_nxt.addr = slave_addr;
                s_nxt.word = port_word;
            end
        end else if (tx_ready) begin
            if (s_r.idx == `RESP_CHARS - 5'h01) begin
                s_nxt.busy = 1'b0;
            end
            s_nxt.idx = s_r.idx + 5'h01;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign busy = s_r.busy;
    assign tx_valid = s_r.busy;
    assign tx_data = ch;

    // ==========================================================
    // checks
    a_frame_len: assert property (@(posedge clk_sys)
        disable iff (!rst_sync_n)
        (busy && tx_ready && s_r.idx == `RESP_CHARS - 5'h01) |=> !busy)
        else $error("reply longer than fifteen characters");
    a_first_hdr: assert property (@(posedge clk_sys)
        disable iff (!rst_sync_n)
        $rose(busy) |-> tx_data == `CH_HEADER)
        else $error("reply does not open with header");
    c_reply_done: cover property (@(posedge clk_sys)
        disable iff (!rst_sync_n) $fell(busy));
endmodule

// [hw/output_status_query.sv]
// ascii query responder returning the output port monitor word
// assumes: rx bytes and tx ready come from a uart on clk_sys;
// port_word is the controller's live output image on clk_sys
//
// Behaviour
// - reply carries the current output-port word, independent of io pattern.
// - address is two hex chars, 01..10, device answers only its own.
// - each frame carries a two-char check before the trailer.
// - reply echoes address and function 03, then byte count 02.
// - reply data is four hex chars, then check and trailer, 15 chars.
// - chars are ascii; header 3A, trailer 0D 0A.
// - bit n of the word is output port n, bit 15 most significant.
`timescale 1ns/1ps
`include "port_query_cfg.svh"
module output_status_query import port_query_pkg::*; (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // configuration
    input wire logic [7:0] own_addr,
    input wire logic [15:0] port_word,
    // receive characters
    input wire logic [7:0] rx_data,
    input wire logic rx_valid,
    // transmit characters
    output logic [7:0] tx_data,
    output logic tx_valid,
    input wire logic tx_ready,
    // status
    output logic frame_dropped
);
    logic rst_m_r, rst_sync_n;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rst_m_r <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_m_r <= 1'b1;
            rst_sync_n <= rst_m_r;
        end
    end

    typedef struct packed {
        pq_state_t st;
        logic [3:0] nib;
        logic [3:0] bidx;
        logic [7:0] sum;
        logic [7:0] addr;
        logic ok;
        logic start;
        logic drop;
    } st_t;
    st_t s_r, s_nxt;

    // decode one ascii hex digit; flag reports a legal digit
    function automatic logic [4:0] hex_val(input logic [7:0] c);
        if (c >= 8'h30 && c <= 8'h39) begin
            hex_val = {1'b1, c[3:0]};
        end else if (c >= 8'h41 && c <= 8'h46) begin
            hex_val = {1'b1, c[3:0] + 4'h9};
        end else begin
            hex_val = 5'h00;
        end
    endfunction

    // expected byte for each fixed field position of the query
    function automatic logic [7:0] fixed_byte(input logic [3:0] i);
        case (i)
            `IDX_FUNC: fixed_byte = `FUNC_READ;
            `IDX_SAH: fixed_byte = 8'(`START_ADDR >> 8);
            `IDX_SAL: fixed_byte = 8'(`START_ADDR & 16'h00FF);
            `IDX_CNH: fixed_byte = 8'(`REG_COUNT >> 8);
            `IDX_CNL: fixed_byte = 8'(`REG_COUNT & 16'h00FF);
            default: fixed_byte = 8'h00;
        endcase
    endfunction

    logic busy;
    logic [4:0] hv;
    logic [7:0] byte_in;
    assign hv = hex_val(rx_data);
    assign byte_in = {s_r.nib, hv[3:0]};

    always_comb begin
        s_nxt = s_r;
        s_nxt.start = 1'b0;
        s_nxt.drop = 1'b0;
        if (rx_valid && rx_data == `CH_HEADER && s_r.st != TX_RUN) begin
            // a header restarts in every state but TX_RUN, so a torn frame cannot lock up
            s_nxt.st = RX_HI;
            s_nxt.bidx = 4'h0;
            s_nxt.sum = 8'h00;
            s_nxt.ok = 1'b1;
        end else begin
            case (s_r.st)
                RX_IDLE: begin
                    s_nxt.st = RX_IDLE;
                end
                RX_HI: begin
                    if (rx_valid) begin
                        s_nxt.nib = hv[3:0];
                        s_nxt.ok = s_r.ok & hv[4];
                        s_nxt.st = RX_LO;
                    end
                end
                RX_LO: begin
                    if (rx_valid) begin
                        s_nxt.ok = s_r.ok & hv[4];
                        s_nxt.sum = s_r.sum + byte_in;
                        if (s_r.bidx == 4'h0) begin
                            s_nxt.addr = byte_in;
                            if (byte_in != own_addr || byte_in < `ADDR_MIN
                                || byte_in > `ADDR_MAX) begin
                                s_nxt.ok = 1'b0;
                            end
                        end else if (s_r.bidx < `QUERY_BYTES &&
                            byte_in != fixed_byte(s_r.bidx)) begin
                            s_nxt.ok = 1'b0;
                        end
                        s_nxt.bidx = s_r.bidx + 4'h1;
                        s_nxt.st = (s_r.bidx == `QUERY_BYTES) ? RX_CR : RX_HI;
                    end
                end
                RX_CR: begin
                    if (rx_valid) begin
                        s_nxt.st = (rx_data == `CH_CR) ? RX_LF : RX_IDLE;
                        s_nxt.drop = (rx_data != `CH_CR);
                    end
                end
                RX_LF: begin
                    if (rx_valid) begin
                        // check byte included: total must wrap to zero
                        if (rx_data == `CH_LF && s_r.ok
                            && s_r.sum == 8'h00) begin
                            s_nxt.st = TX_RUN;
                            s_nxt.start = 1'b1;
                        end else begin
                            s_nxt.st = RX_IDLE;
                            s_nxt.drop = 1'b1;
                        end
                    end
                end
                TX_RUN: begin
                    if (!s_r.start && !busy) begin
                        s_nxt.st = RX_IDLE;
                    end
                end
                default: s_nxt.st = RX_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign frame_dropped = s_r.drop;

    hex_tx_framer u_framer (
        .clk_sys(clk_sys),
        .rst_sync_n(rst_sync_n),
        .start(s_r.start),
        .slave_addr(s_r.addr),
        .port_word(port_word),
        .busy(busy),
        .tx_data(tx_data),
        .tx_valid(tx_valid),
        .tx_ready(tx_ready)
    );

    // ==========================================================
    // checks
    a_reply_start: assert property (@(posedge clk_sys)
        disable iff (!rst_sync_n)
        s_r.start |=> tx_valid)
        else $error("accepted query not answered");
    a_drop_quiet: assert property (@(posedge clk_sys)
        disable iff (!rst_sync_n)
        s_r.drop |-> !tx_valid)
        else $error("reply sent for dropped frame");
    a_addr_match: assert property (@(posedge clk_sys)
        disable iff (!rst_sync_n)
        s_r.start |-> s_r.addr == own_addr)
        else $error("reply to foreign address");
    a_addr_range: assert property (@(posedge clk_sys)
        disable iff (!rst_sync_n)
        s_r.start |-> s_r.addr >= `ADDR_MIN && s_r.addr <= `ADDR_MAX)
        else $error("reply to address out of range");
    a_check_ok: assert property (@(posedge clk_sys)
        disable iff (!rst_sync_n)
        s_r.start |-> s_r.sum == 8'h00)
        else $error("reply with failing check");
    a_fixed_fields: assert property (@(posedge clk_sys)
        disable iff (!rst_sync_n)
        s_r.start |-> s_r.ok)
        else $error("reply to wrong function or address");
    a_tail_cr: assert property (@(posedge clk_sys)
        disable iff (!rst_sync_n)
        (tx_valid && tx_ready && tx_data == `CH_CR) |=> tx_data == `CH_LF)
        else $error("cr not followed by lf");
    a_word_live: assert property (@(posedge clk_sys)
        disable iff (!rst_sync_n)
        s_r.start |=> u_framer.s_r.word == $past(port_word))
        else $error("reply word not the live port value");
    c_restart: cover property (@(posedge clk_sys) disable iff (!rst_sync_n)
        rx_valid && rx_data == `CH_HEADER
        && (s_r.st == RX_HI || s_r.st == RX_LO));
    c_answered: cover property (@(posedge clk_sys)
        disable iff (!rst_sync_n) s_r.start);
    c_dropped: cover property (@(posedge clk_sys)
        disable iff (!rst_sync_n) s_r.drop);
    c_stall: cover property (@(posedge clk_sys)
        disable iff (!rst_sync_n) tx_valid && !tx_ready);
endmodule

// [sim/host_model.sv]
// serial master model: sends ascii query chars, takes reply chars
// assumes: responder on clk_sys; bench drives its calls at falling edges
`timescale 1ns/1ps
module host_model (
    // clock
    input wire logic clk_sys,
    // query characters
    output logic [7:0] rx_data,
    output logic rx_valid,
    // reply characters
    input wire logic [7:0] tx_data,
    input wire logic tx_valid,
    output logic tx_ready
);
    logic slow;
    logic [1:0] phase_r;
    logic [7:0] reply_q[$];
    initial begin
        rx_data = 8'h00;
        rx_valid = 1'b0;
        slow = 1'b0;
        phase_r = 2'h0;
        tx_ready = 1'b0;
    end
    // slow mode accepts one char in four, like a busy transmitter
    always @(negedge clk_sys) begin
        phase_r <= phase_r + 2'h1;
        tx_ready <= !slow || (phase_r == 2'h3);
    end
    always @(posedge clk_sys) begin
        if (tx_valid && tx_ready) begin
            reply_q.push_back(tx_data);
        end
    end
    // one char per cycle; idle line shows inverted data, never a stale char
    task automatic send(input logic [7:0] q[$]);
        foreach (q[i]) begin
            @(negedge clk_sys);
            rx_data = q[i];
            rx_valid = 1'b1;
        end
        @(negedge clk_sys);
        rx_valid = 1'b0;
        rx_data = ~rx_data;
    endtask
endmodule

// [sim/output_status_query_tb.sv]
// self-checking bench for the ascii output-status query responder
// assumes: host_model drives the char stream, 250 MHz clk_sys
`timescale 1ns/1ps
module output_status_query_tb;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] own_addr = 8'h01;
    logic [15:0] port_word = 16'h0000;
    logic [7:0] rx_data;
    logic rx_valid;
    logic [7:0] tx_data;
    logic tx_valid;
    logic tx_ready;
    logic frame_dropped;
    int bad_count = 0;
    int samples_checked = 0;
    int drop_cnt = 0;
    int cyc = 0;
    always #2 clk_sys = ~clk_sys;
    output_status_query DUT (.clk_sys(clk_sys), .rst_n(rst_n),
        .own_addr(own_addr), .port_word(port_word), .rx_data(rx_data),
        .rx_valid(rx_valid), .tx_data(tx_data), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .frame_dropped(frame_dropped));
    host_model HOST (.clk_sys(clk_sys), .rx_data(rx_data),
        .rx_valid(rx_valid), .tx_data(tx_data), .tx_valid(tx_valid),
        .tx_ready(tx_ready));
    // ========================================
    // verdict and watchdog
    task give_verdict;
        if (bad_count == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cyc++;
        if (frame_dropped === 1'b1) begin
            drop_cnt++;
        end
        if (cyc == 20000) begin
            bad_count++;
            give_verdict();
        end
    end
    // ========================================
    // helpers
    task automatic check(input string what, input logic [15:0] exp,
        input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            $display("[ERR] %s exp %h got %h", what, exp, got);
            bad_count++;
        end
    endtask
    function automatic void put(ref logic [7:0] q[$], input logic [7:0] b);
        q.push_back(b[7:4] < 4'hA ? 8'h30 + b[7:4] : 8'h37 + b[7:4]);
        q.push_back(b[3:0] < 4'hA ? 8'h30 + b[3:0] : 8'h37 + b[3:0]);
    endfunction
    // sends one query; skew spoils the check byte; good means a reply is due
    task automatic run_query(input logic [7:0] addr, input logic [15:0] start,
        input logic [7:0] skew, input logic good);
        logic [7:0] q[$];
        logic [7:0] e[$];
        logic [7:0] sum;
        int drops;
        int n;
        q = {8'h3A};
        sum = addr + 8'h03 + start[15:8] + start[7:0] + 8'h01;
        put(q, addr);
        put(q, 8'h03);
        put(q, start[15:8]);
        put(q, start[7:0]);
        put(q, 8'h00);
        put(q, 8'h01);
        put(q, 8'h00 - sum + skew);
        q.push_back(8'h0D);
        q.push_back(8'h0A);
        drops = drop_cnt;
        HOST.reply_q.delete();
        HOST.send(q);
        n = 0;
        while (HOST.reply_q.size() < 15 && n < 120) begin
            @(posedge clk_sys);
            n++;
        end
        repeat (4) @(posedge clk_sys);
        // look at settled outputs, away from the launching edge
        @(negedge clk_sys);
        if (good) begin
            e = {8'h3A};
            sum = addr + 8'h03 + 8'h02 + port_word[15:8] + port_word[7:0];
            put(e, addr);
            put(e, 8'h03);
            put(e, 8'h02);
            put(e, port_word[15:8]);
            put(e, port_word[7:0]);
            put(e, 8'h00 - sum);
            e.push_back(8'h0D);
            e.push_back(8'h0A);
            check("reply length", 16'h000F, 16'(HOST.reply_q.size()));
            foreach (e[i]) begin
                check("reply char", {8'h00, e[i]}, {8'h00, HOST.reply_q[i]});
            end
            check("drop count", 16'(drops), 16'(drop_cnt));
            check("idle after reply", 16'h0000, {15'h0000, tx_valid});
        end else begin
            check("silent length", 16'h0000, 16'(HOST.reply_q.size()));
            check("drop count", 16'(drops + 1), 16'(drop_cnt));
        end
    endtask
    // ========================================
    // scenarios
    task automatic s_sample;
        @(negedge clk_sys);
        own_addr = 8'h01;
        port_word = 16'h7400;
        run_query(8'h01, 16'h9004, 8'h00, 1'b1);
    endtask
    task automatic s_top_addr_slow;
        @(negedge clk_sys);
        own_addr = 8'h10;
        port_word = 16'h8001;
        HOST.slow = 1'b1;
        run_query(8'h10, 16'h9004, 8'h00, 1'b1);
        @(negedge clk_sys);
        port_word = 16'h00A5;
        run_query(8'h10, 16'h9004, 8'h00, 1'b1);
        HOST.slow = 1'b0;
    endtask
    task automatic s_refusals;
        @(negedge clk_sys);
        own_addr = 8'h10;
        run_query(8'h10, 16'h9004, 8'h01, 1'b0);
        run_query(8'h05, 16'h9004, 8'h00, 1'b0);
        run_query(8'h10, 16'h9005, 8'h00, 1'b0);
        @(negedge clk_sys);
        own_addr = 8'h11;
        run_query(8'h11, 16'h9004, 8'h00, 1'b0);
    endtask
    // a header inside a frame restarts it; the torn part is not answered
    task automatic s_torn;
        logic [7:0] p[$];
        p = {8'h3A, 8'h30, 8'h31};
        @(negedge clk_sys);
        own_addr = 8'h01;
        port_word = 16'h1234;
        HOST.send(p);
        run_query(8'h01, 16'h9004, 8'h00, 1'b1);
    endtask
    // ========================================
    // main sequence
    initial begin
        repeat (8) @(posedge clk_sys);
        @(negedge clk_sys);
        rst_n = 1'b1;
        repeat (3) @(posedge clk_sys);
        s_sample();
        s_top_addr_slow();
        s_refusals();
        s_torn();
        s_sample();
        give_verdict();
    end
endmodule
